// >>> rtl/cft_consts.svh
// constants shared by both ends of the frame formatter link
// assumes one bus bit per mclk_i cycle and no bit stuffing on the line
`ifndef CFT_CONSTS_SVH
`define CFT_CONSTS_SVH
`define CFT_DOM 1'b0
`define CFT_REC 1'b1
`define CFT_IDLE_BITS 4'hb
`define CFT_IFS_BITS 7'h03
`define CFT_EOF_BITS 7'h07
`define CFT_FLAG_BITS 7'h06
`define CFT_DELIM_BITS 7'h08
`define CFT_CRC_BITS 7'h0f
`define CFT_CRC_INIT 15'h0000
`define CFT_CRC_POLY 15'h4599
`define CFT_STD_ARB_BITS 7'h0c
`define CFT_EXT_ARB_BITS 7'h20
`define CFT_STD_HDR_BITS 7'h12
`define CFT_EXT_HDR_BITS 7'h26
`define CFT_IDE_POS 7'h0c
`define CFT_MAX_BYTES 4'h8
`endif

// >>> rtl/cft_pkg.sv
// types and shared arithmetic of the frame formatter link
// assumes cft_consts.svh is on the include path
`include "cft_consts.svh"
package cft_pkg;
    typedef enum logic [3:0] {
        TX_SYNC, TX_IDLE, TX_SOF, TX_HDR, TX_DATA, TX_CRC, TX_CRCD,
        TX_ACKS, TX_ACKD, TX_EOF, TX_FLAG, TX_DELIM, TX_IFS
    } cft_tx_st_e;

    typedef enum logic [3:0] {
        RX_SYNC, RX_IDLE, RX_HDR, RX_DATA, RX_CRC, RX_CRCD,
        RX_ACKS, RX_ACKD, RX_EOF, RX_FLAG, RX_DELIM, RX_IFS
    } cft_rx_st_e;

    typedef struct packed {
        cft_tx_st_e st;
        logic [6:0] cnt;
        logic [3:0] idle;
        logic [37:0] hdr;
        logic [6:0] hlen;
        logic [6:0] alen;
        logic [63:0] dat;
        logic [6:0] dlen;
        logic [14:0] crc;
        logic oe;
        logic busy;
        logic done;
        logic err;
        logic lost;
    } cft_tx_s;

    typedef struct packed {
        cft_rx_st_e st;
        logic [6:0] cnt;
        logic [3:0] idle;
        logic [37:0] hdr;
        logic ide;
        logic rtr;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] dat;
        logic [6:0] dlen;
        logic [14:0] crc;
        logic [14:0] rcrc;
        logic ok;
        logic oe;
        logic valid;
        logic err;
        logic ovl;
    } cft_rx_s;

    function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
        logic [14:0] r;
        r = {c[13:0], 1'b0};
        if (b ^ c[14])
        begin
            r = r ^ `CFT_CRC_POLY;
        end
        return r;
    endfunction

    // payload length in bits; remote frames carry none, codes above 8 mean 8
    function automatic logic [6:0] payload_bits(input logic rtr, input logic [3:0] dlc);
        logic [3:0] n;
        n = (dlc > `CFT_MAX_BYTES) ? `CFT_MAX_BYTES : dlc;
        if (rtr)
        begin
            n = 4'h0;
        end
        return {n, 3'b000};
    endfunction
endpackage

// >>> rtl/cft_bus_if.sv
// wired-and bus shared by the formatter end and the far node end
// assumes both ends run on the same bit clock; each end only pulls dominant
`timescale 1ns/1ps
`default_nettype none
interface cft_bus_if;
    logic dev_oe;
    logic node_oe;
    logic line;

    // dominant (0) wins whenever either end drives
    assign line = ~(dev_oe | node_oe);

    modport dev (output dev_oe, input line);
    modport node (output node_oe, input line);
endinterface
`default_nettype wire

// >>> rtl/cft_tx_end.sv
// formatter end: builds data and remote frames, makes error, overload
// and interframe-space sequences itself
// assumes one bus bit per clock, bus from logic on the same clock
//
// How it works
// - only data, remote, error, overload, interframe space
// - hardware makes error, overload and spacing sequences
// - standard or extended layout chosen per frame
// - identifier is 11 or 29 bits
// - seven fields in fixed order
// - payload zero to eight bytes only
// - start of frame is one dominant bit
// - remote frame asks owner for same identifier
// - detected error answered with an error frame
// - not ready node sends overload frame
// - interframe space precedes every data or remote frame
// - arbitration field carries the frame priority
// - control field holds reserved bits and length
// - crc field lets receivers detect corruption
// - acknowledge field carries receiver's correct-reception mark
// - dominant is 0, recessive 1, wired-and bus
// - end of frame is seven recessive bits
// - fifteen-bit crc then one delimiter bit
`timescale 1ns/1ps
`default_nettype none
`include "cft_consts.svh"
module cft_tx_end (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire logic ide_i,
    input wire logic rtr_i,
    input wire logic [28:0] id_i,
    input wire logic [3:0] dlc_i,
    input wire logic [63:0] data_i,
    input wire logic not_ready_i,
    output logic busy_o,
    output logic done_o,
    output logic err_o,
    output logic lost_o,
    cft_bus_if.dev bus
);
    cft_pkg::cft_tx_s s_r;
    cft_pkg::cft_tx_s s_nxt;
    logic sent;
    logic em_hdr;
    logic em_dat;
    logic em_crc;
    logic drives;

    // header left-aligned: arbitration then control field
    function automatic logic [37:0] build_hdr(input logic ide, input logic rtr,
                                              input logic [28:0] id, input logic [3:0] dlc);
        logic [37:0] h;
        if (ide)
        begin
            h = {id[28:18], `CFT_REC, `CFT_REC, id[17:0], rtr, `CFT_DOM, `CFT_DOM, dlc};
        end
        else
        begin
            h = {id[10:0], rtr, `CFT_DOM, `CFT_DOM, dlc, 20'h00000};
        end
        return h;
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        sent = ~s_r.oe;
        em_hdr = 1'b0;
        em_dat = 1'b0;
        em_crc = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.lost = 1'b0;
        s_nxt.cnt = s_r.cnt + 7'h01;
        if (bus.line == `CFT_DOM)
        begin
            s_nxt.idle = 4'h0;
        end
        else if (s_r.idle != `CFT_IDLE_BITS)
        begin
            s_nxt.idle = s_r.idle + 4'h1;
        end
        drives = 1'b0;
        case (s_r.st)
            cft_pkg::TX_SYNC:
            begin
                s_nxt.oe = 1'b0;
                if (s_nxt.idle == `CFT_IDLE_BITS)
                begin
                    s_nxt.st = cft_pkg::TX_IDLE;
                end
            end
            cft_pkg::TX_IDLE:
            begin
                // someone else began a frame: wait for the bus to go idle
                if (bus.line == `CFT_DOM)
                begin
                    s_nxt.st = cft_pkg::TX_SYNC;
                end
                else if (req_i)
                begin
                    s_nxt.hdr = build_hdr(ide_i, rtr_i, id_i, dlc_i);
                    s_nxt.hlen = ide_i ? `CFT_EXT_HDR_BITS : `CFT_STD_HDR_BITS;
                    s_nxt.alen = ide_i ? `CFT_EXT_ARB_BITS : `CFT_STD_ARB_BITS;
                    s_nxt.dat = data_i;
                    s_nxt.dlen = cft_pkg::payload_bits(rtr_i, dlc_i);
                    s_nxt.crc = cft_pkg::crc_step(`CFT_CRC_INIT, `CFT_DOM);
                    s_nxt.oe = 1'b1;
                    s_nxt.busy = 1'b1;
                    s_nxt.st = cft_pkg::TX_SOF;
                end
            end
            cft_pkg::TX_SOF:
            begin
                drives = 1'b1;
                em_hdr = 1'b1;
                s_nxt.cnt = 7'h00;
                s_nxt.st = cft_pkg::TX_HDR;
            end
            cft_pkg::TX_HDR:
            begin
                drives = 1'b1;
                if (s_r.cnt == s_r.hlen - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    if (s_r.dlen != 7'h00)
                    begin
                        em_dat = 1'b1;
                        s_nxt.st = cft_pkg::TX_DATA;
                    end
                    else
                    begin
                        em_crc = 1'b1;
                        s_nxt.st = cft_pkg::TX_CRC;
                    end
                end
                else
                begin
                    em_hdr = 1'b1;
                end
            end
            cft_pkg::TX_DATA:
            begin
                drives = 1'b1;
                if (s_r.cnt == s_r.dlen - 7'h01)
                begin
                    em_crc = 1'b1;
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::TX_CRC;
                end
                else
                begin
                    em_dat = 1'b1;
                end
            end
            cft_pkg::TX_CRC:
            begin
                drives = 1'b1;
                if (s_r.cnt == `CFT_CRC_BITS - 7'h01)
                begin
                    s_nxt.oe = 1'b0;
                    s_nxt.st = cft_pkg::TX_CRCD;
                end
                else
                begin
                    em_crc = 1'b1;
                end
            end
            cft_pkg::TX_CRCD:
            begin
                drives = 1'b1;
                s_nxt.st = cft_pkg::TX_ACKS;
            end
            cft_pkg::TX_ACKS:
            begin
                // a receiver must pull the slot dominant
                if (bus.line == `CFT_REC)
                begin
                    s_nxt.st = cft_pkg::TX_FLAG;
                    s_nxt.cnt = 7'h00;
                    s_nxt.oe = 1'b1;
                    s_nxt.err = 1'b1;
                    s_nxt.busy = 1'b0;
                end
                else
                begin
                    s_nxt.st = cft_pkg::TX_ACKD;
                end
            end
            cft_pkg::TX_ACKD:
            begin
                drives = 1'b1;
                s_nxt.cnt = 7'h00;
                s_nxt.st = cft_pkg::TX_EOF;
            end
            cft_pkg::TX_EOF:
            begin
                drives = 1'b1;
                if (s_r.cnt == `CFT_EOF_BITS - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = cft_pkg::TX_IFS;
                end
            end
            cft_pkg::TX_FLAG:
            begin
                s_nxt.oe = 1'b1;
                if (s_r.cnt == `CFT_FLAG_BITS - 7'h01)
                begin
                    s_nxt.oe = 1'b0;
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::TX_DELIM;
                end
            end
            cft_pkg::TX_DELIM:
            begin
                // other nodes' flags may overlap ours; count only recessive bits
                s_nxt.oe = 1'b0;
                if (bus.line == `CFT_DOM)
                begin
                    s_nxt.cnt = 7'h00;
                end
                else if (s_r.cnt == `CFT_DELIM_BITS - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::TX_IFS;
                end
            end
            cft_pkg::TX_IFS:
            begin
                s_nxt.oe = 1'b0;
                if (bus.line == `CFT_DOM)
                begin
                    s_nxt.st = cft_pkg::TX_SYNC;
                end
                else if (s_r.cnt == 7'h00 && not_ready_i)
                begin
                    // flag starts inside the gap, so no node takes it for a start of frame
                    s_nxt.cnt = 7'h00;
                    s_nxt.oe = 1'b1;
                    s_nxt.st = cft_pkg::TX_FLAG;
                end
                else if (s_r.cnt == `CFT_IFS_BITS - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::TX_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = cft_pkg::TX_SYNC;
            end
        endcase

        if (em_hdr)
        begin
            s_nxt.oe = ~s_r.hdr[37];
            s_nxt.hdr = s_r.hdr << 1;
            s_nxt.crc = cft_pkg::crc_step(s_r.crc, s_r.hdr[37]);
        end
        if (em_dat)
        begin
            s_nxt.oe = ~s_r.dat[63];
            s_nxt.dat = s_r.dat << 1;
            s_nxt.crc = cft_pkg::crc_step(s_r.crc, s_r.dat[63]);
        end
        if (em_crc)
        begin
            s_nxt.oe = ~s_r.crc[14];
            s_nxt.crc = s_r.crc << 1;
        end

        // recessive sent but dominant read back
        if (drives && sent == `CFT_REC && bus.line == `CFT_DOM)
        begin
            s_nxt.busy = 1'b0;
            s_nxt.cnt = 7'h00;
            if (s_r.st == cft_pkg::TX_HDR && s_r.cnt < s_r.alen)
            begin
                s_nxt.lost = 1'b1;
                s_nxt.oe = 1'b0;
                s_nxt.st = cft_pkg::TX_SYNC;
            end
            else
            begin
                s_nxt.err = 1'b1;
                s_nxt.oe = 1'b1;
                s_nxt.st = cft_pkg::TX_FLAG;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            s_r <= '0;
            s_r.st <= cft_pkg::TX_SYNC;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.dev_oe = s_r.oe;
    assign busy_o = s_r.busy;
    assign done_o = s_r.done;
    assign err_o = s_r.err;
    assign lost_o = s_r.lost;
endmodule
`default_nettype wire

// >>> rtl/cft_rx_end.sv
// far node end: takes frames off the bus, checks crc, acknowledges,
// raises error frames and overload frames when not ready
// assumes one bus bit per clock, bus from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "cft_consts.svh"
module cft_rx_end (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ready_i,
    output logic rx_valid_o,
    output logic rx_ide_o,
    output logic rx_rtr_o,
    output logic [28:0] rx_id_o,
    output logic [3:0] rx_dlc_o,
    output logic [63:0] rx_data_o,
    output logic rx_err_o,
    cft_bus_if.node bus
);
    cft_pkg::cft_rx_s s_r;
    cft_pkg::cft_rx_s s_nxt;
    logic b;
    logic ide;
    logic [37:0] h;
    logic go_flag;

    always_comb
    begin
        s_nxt = s_r;
        b = bus.line;
        go_flag = 1'b0;
        s_nxt.valid = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.cnt = s_r.cnt + 7'h01;
        h = {s_r.hdr[36:0], b};
        ide = (s_r.cnt == `CFT_IDE_POS) ? b : s_r.ide;
        if (b == `CFT_DOM)
        begin
            s_nxt.idle = 4'h0;
        end
        else if (s_r.idle != `CFT_IDLE_BITS)
        begin
            s_nxt.idle = s_r.idle + 4'h1;
        end
        case (s_r.st)
            cft_pkg::RX_SYNC:
            begin
                if (s_nxt.idle == `CFT_IDLE_BITS)
                begin
                    s_nxt.st = cft_pkg::RX_IDLE;
                end
            end
            cft_pkg::RX_IDLE:
            begin
                if (b == `CFT_DOM)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.crc = cft_pkg::crc_step(`CFT_CRC_INIT, b);
                    s_nxt.st = cft_pkg::RX_HDR;
                end
            end
            cft_pkg::RX_HDR:
            begin
                s_nxt.hdr = h;
                s_nxt.ide = ide;
                s_nxt.crc = cft_pkg::crc_step(s_r.crc, b);
                if (s_r.cnt > `CFT_IDE_POS &&
                    s_r.cnt == (ide ? `CFT_EXT_HDR_BITS : `CFT_STD_HDR_BITS) - 7'h01)
                begin
                    s_nxt.rtr = h[6];
                    s_nxt.dlc = h[3:0];
                    s_nxt.id = ide ? {h[37:27], h[24:7]} : {18'h00000, h[17:7]};
                    s_nxt.dlen = cft_pkg::payload_bits(h[6], h[3:0]);
                    s_nxt.dat = 64'h0000000000000000;
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = (s_nxt.dlen != 7'h00) ? cft_pkg::RX_DATA : cft_pkg::RX_CRC;
                end
            end
            cft_pkg::RX_DATA:
            begin
                s_nxt.dat = {s_r.dat[62:0], b};
                s_nxt.crc = cft_pkg::crc_step(s_r.crc, b);
                if (s_r.cnt == s_r.dlen - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::RX_CRC;
                end
            end
            cft_pkg::RX_CRC:
            begin
                s_nxt.rcrc = {s_r.rcrc[13:0], b};
                if (s_r.cnt == `CFT_CRC_BITS - 7'h01)
                begin
                    s_nxt.ok = (s_nxt.rcrc == s_r.crc);
                    s_nxt.st = cft_pkg::RX_CRCD;
                end
            end
            cft_pkg::RX_CRCD:
            begin
                if (b == `CFT_DOM)
                begin
                    go_flag = 1'b1;
                end
                else
                begin
                    // ack slot driven only for a clean frame
                    s_nxt.oe = s_r.ok;
                    s_nxt.st = cft_pkg::RX_ACKS;
                end
            end
            cft_pkg::RX_ACKS:
            begin
                s_nxt.oe = 1'b0;
                s_nxt.st = cft_pkg::RX_ACKD;
            end
            cft_pkg::RX_ACKD:
            begin
                go_flag = (b == `CFT_DOM) || !s_r.ok;
                s_nxt.cnt = 7'h00;
                s_nxt.st = cft_pkg::RX_EOF;
            end
            cft_pkg::RX_EOF:
            begin
                if (b == `CFT_DOM)
                begin
                    go_flag = 1'b1;
                end
                else if (s_r.cnt == `CFT_EOF_BITS - 7'h01)
                begin
                    s_nxt.valid = 1'b1;
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::RX_IFS;
                    if (!ready_i)
                    begin
                        s_nxt.ovl = 1'b1;
                        s_nxt.oe = 1'b1;
                        s_nxt.st = cft_pkg::RX_FLAG;
                    end
                end
            end
            cft_pkg::RX_FLAG:
            begin
                if (s_r.cnt == `CFT_FLAG_BITS - 7'h01)
                begin
                    s_nxt.oe = 1'b0;
                    s_nxt.cnt = 7'h00;
                    s_nxt.st = cft_pkg::RX_DELIM;
                end
            end
            cft_pkg::RX_DELIM:
            begin
                if (b == `CFT_DOM)
                begin
                    s_nxt.cnt = 7'h00;
                end
                else if (s_r.cnt == `CFT_DELIM_BITS - 7'h01)
                begin
                    s_nxt.cnt = 7'h00;
                    s_nxt.ovl = 1'b0;
                    s_nxt.st = cft_pkg::RX_IFS;
                end
            end
            cft_pkg::RX_IFS:
            begin
                if (b == `CFT_DOM)
                begin
                    s_nxt.st = cft_pkg::RX_SYNC;
                end
                else if (s_r.cnt == `CFT_IFS_BITS - 7'h01)
                begin
                    s_nxt.st = cft_pkg::RX_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = cft_pkg::RX_SYNC;
            end
        endcase

        // flag overrides the field decoding above
        if (go_flag)
        begin
            s_nxt.err = 1'b1;
            s_nxt.oe = 1'b1;
            s_nxt.cnt = 7'h00;
            s_nxt.st = cft_pkg::RX_FLAG;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            s_r <= '0;
            s_r.st <= cft_pkg::RX_SYNC;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.node_oe = s_r.oe;
    assign rx_valid_o = s_r.valid;
    assign rx_ide_o = s_r.ide;
    assign rx_rtr_o = s_r.rtr;
    assign rx_id_o = s_r.id;
    assign rx_dlc_o = s_r.dlc;
    assign rx_data_o = s_r.dat;
    assign rx_err_o = s_r.err;
endmodule
`default_nettype wire

// >>> sim/cft_link_asserts.sv
// wire checks for the formatter link, watching the shared bus only
// assumes one bus bit per mclk_i cycle and both ends on that clock
`timescale 1ns/1ps
`default_nettype none
module cft_link_asserts (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic dev_oe,
    input wire logic node_oe,
    input wire logic line
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    AST_WIRED_AND: assert property (line == !(dev_oe || node_oe))
        else $error("bus level is not the wired-and of both drivers");
    // both ends must first see 11 recessive bits, so nobody drives early
    AST_RESET_QUIET: assert property ($fell(srst_i) |-> (!dev_oe && !node_oe)[*8])
        else $error("bus driven right after reset");
    AST_ACK_OWN: assert property ($rose(node_oe) |-> !dev_oe)
        else $error("formatter drives while node starts to drive");
    AST_ACK_AFTER_DELIM: assert property ($rose(node_oe) |-> $past(line))
        else $error("node drive not preceded by a recessive bit");
    AST_NODE_FLAG: assert property ($rose(node_oe) |->
        (##1 !node_oe) or (node_oe[*6] ##1 !node_oe))
        else $error("node drive is neither one ack bit nor a six bit flag");
    AST_FLAG_DELIM: assert property ($rose(node_oe) ##1 node_oe[*5] ##1 !node_oe
        |-> !node_oe[*7])
        else $error("node flag not followed by a recessive delimiter");
    AST_EOF_REC: assert property ($fell(node_oe) && !$past(node_oe, 2) |-> line[*8])
        else $error("ack delimiter and end of frame not recessive");
    // an overload flag may start in the second gap bit; nothing else may
    AST_IFS_GAP: assert property ($fell(node_oe) && !$past(node_oe, 2)
        |-> !dev_oe[*8] ##1 (!dev_oe[*3] or (!dev_oe ##1 dev_oe[*6])))
        else $error("formatter drove in the interframe space other than an overload flag");
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// bench: formatter end and node end on one link, plus a second
// formatter end whose far side never acknowledges
// assumes the rtl files and cft_consts.svh are on the include path
`timescale 1ns/1ps
`default_nettype none
`include "cft_consts.svh"
module tb_top;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req = 1'b0;
    logic ide = 1'b0;
    logic rtr = 1'b0;
    logic [28:0] id = 29'h0;
    logic [3:0] dlc = 4'h0;
    logic [63:0] dat = 64'h0;
    logic not_ready = 1'b0;
    logic ready = 1'b1;
    logic busy, done, err, err2, rx_valid, rx_ide, rx_rtr, lost, rx_err;
    logic [28:0] rx_id;
    logic [3:0] rx_dlc;
    logic [63:0] rx_data;
    logic exp_bits [0:159];
    int len, nb, miscompares, checks, cycles, err2_seen, bad_seen;

    always #20 mclk_i = ~mclk_i;

    cft_bus_if cft_bus_if_inst ();
    cft_bus_if cft_bus_if_noack_inst ();
    assign cft_bus_if_noack_inst.node_oe = 1'b0;
    cft_tx_end cft_tx_end_inst (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .ide_i(ide),
        .rtr_i(rtr), .id_i(id), .dlc_i(dlc), .data_i(dat), .not_ready_i(not_ready),
        .busy_o(busy), .done_o(done), .err_o(err), .lost_o(lost), .bus(cft_bus_if_inst.dev));
    cft_tx_end cft_tx_end_noack_inst (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
        .ide_i(ide), .rtr_i(rtr), .id_i(id), .dlc_i(dlc), .data_i(dat), .not_ready_i(1'b0),
        .busy_o(), .done_o(), .err_o(err2), .lost_o(), .bus(cft_bus_if_noack_inst.dev));
    cft_rx_end cft_rx_end_inst (.mclk_i(mclk_i), .srst_i(srst_i), .ready_i(ready),
        .rx_valid_o(rx_valid), .rx_ide_o(rx_ide), .rx_rtr_o(rx_rtr), .rx_id_o(rx_id),
        .rx_dlc_o(rx_dlc), .rx_data_o(rx_data), .rx_err_o(rx_err), .bus(cft_bus_if_inst.node));
    cft_link_asserts cft_link_asserts_inst (.mclk_i(mclk_i), .srst_i(srst_i),
        .dev_oe(cft_bus_if_inst.dev_oe), .node_oe(cft_bus_if_inst.node_oe),
        .line(cft_bus_if_inst.line));

    task automatic stop_test();
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (e !== g)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic add(input logic [63:0] v, input int w);
        for (int k = w - 1; k >= 0; k--)
        begin
            exp_bits[len] = v[k];
            len++;
        end
    endtask

    // expected line bits from start of frame to the last end bit
    task automatic build();
        logic [14:0] c;
        len = 0;
        c = 15'h0;
        nb = rtr ? 0 : ((dlc > 4'h8) ? 8 : int'(dlc));
        add(64'h0, 1);
        if (ide)
        begin
            add(64'(id[28:18]), 11);
            add(64'h3, 2);
            add(64'(id[17:0]), 18);
        end
        else
            add(64'(id[10:0]), 11);
        add(64'(rtr), 1);
        add(64'h0, 2);
        add(64'(dlc), 4);
        add(dat >> (64 - 8 * nb), 8 * nb);
        for (int i = 0; i < len; i++)
            c = {c[13:0], 1'b0} ^ ((exp_bits[i] ^ c[14]) ? `CFT_CRC_POLY : 15'h0);
        add(64'(c), 15);
        add(64'h5, 3);
        add(64'h7f, 7);
    endtask

    task automatic send();
        int t;
        build();
        req = 1'b1;
        t = 0;
        @(negedge mclk_i);
        while (cft_bus_if_inst.line !== 1'b0 && t < 200)
        begin
            @(negedge mclk_i);
            t++;
        end
        req = 1'b0;
        chk("busy", 64'h1, busy);
        for (int i = 0; i < len; i++)
        begin
            chk("line", exp_bits[i], cft_bus_if_inst.line);
            @(negedge mclk_i);
        end
        chk("done", 64'h1, done);
        chk("valid", 64'h1, rx_valid);
        chk("err", 64'h0, err);
        chk("ide", ide, rx_ide);
        chk("rtr", rtr, rx_rtr);
        chk("id", ide ? id : id & 29'h7ff, rx_id);
        chk("dlc", dlc, rx_dlc);
        chk("data", dat >> (64 - 8 * nb), rx_data);
    endtask

    task automatic count_dom(output int n);
        n = 0;
        repeat (24)
        begin
            n += int'(cft_bus_if_inst.line === 1'b0);
            @(negedge mclk_i);
            // one cycle is enough: the formatter only looks in its first gap bit
            not_ready = 1'b0;
        end
    endtask

    // sampled off the launching edge so a one-cycle pulse is never missed
    always @(negedge mclk_i)
    begin
        cycles++;
        err2_seen += int'(err2 === 1'b1);
        bad_seen += int'(lost !== 1'b0) + int'(rx_err !== 1'b0);
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        int n;
        void'($urandom(34));
        repeat (8) @(negedge mclk_i);
        srst_i = 1'b0;
        for (int f = 0; f < 36; f++)
        begin
            // first six frames are hand-picked layout and length corners
            ide = (f < 6) ? f[0] : 1'($urandom);
            rtr = (f < 6) ? (f == 3 || f == 4) : (($urandom % 4) == 0);
            id = (f < 6) ? ((f == 1 || f == 2) ? 29'h1f7ffbff : 29'h0) : 29'($urandom);
            dlc = (f < 6) ? 4'(24'h883f80 >> (4 * f)) : 4'($urandom);
            dat = {$urandom, $urandom};
            ready = (f != 8);
            send();
            not_ready = (f == 9);
            if (f == 8 || f == 9)
            begin
                count_dom(n);
                chk("overload", 64'h6, 64'(n));
            end
        end
        chk("noack", 64'h1, 64'(err2_seen > 0));
        chk("lost_or_rx_err", 64'h0, 64'(bad_seen));
        stop_test();
    end
endmodule
`default_nettype wire
